// [design/clock_reset_power_pkg.sv]
// Constants, types and enumerations shared by the clock, reset and power control files
package clock_reset_power_pkg;

	// Clocking and timing
	localparam int          MCLK_MHZ          = 100;
	localparam int          FLASH_ROW_MS      = 20;
	localparam int          FLASH_ROW_CYCLES  = FLASH_ROW_MS * 1000 * MCLK_MHZ;
	localparam logic [3:0]  RESET_HOLD_CYCLES = 4'h8;

	// Main oscillator settings in MHz
	localparam logic [5:0]  MAIN_RESET_MHZ = 6'h18;
	localparam logic [5:0]  MAIN_MIN_MHZ   = 6'h03;
	localparam logic [5:0]  MAIN_MAX_MHZ   = 6'h30;
	localparam logic [5:0]  MAIN_FLASH_MHZ = 6'h30;

	// Low-voltage threshold code: 1.8 V plus code times 0.1 V, up to 4.5 V
	localparam logic [4:0]  VOLT_CODE_MAX = 5'h1b;

	// Divider bank
	localparam int NUM_DIV   = 12;
	localparam int NUM_FRAC  = 2;
	localparam int NUM_PCLK  = 16;
	localparam int DIV_W     = 16;

	// Oscillator source indices
	localparam int NUM_SRC = 5;
	typedef enum logic [2:0] {
		SRC_MAIN  = 3'h0,
		SRC_SLOW  = 3'h1,
		SRC_FAST  = 3'h2,
		SRC_WATCH = 3'h3,
		SRC_EXT   = 3'h4
	} clk_src_t;

	// Power modes, Gray-coded along wait, active, sleep, deep, hibernate, stop
	typedef enum logic [2:0] {
		PM_WAIT  = 3'h0,
		PM_ACT   = 3'h1,
		PM_SLEEP = 3'h3,
		PM_DEEP  = 3'h2,
		PM_HIB   = 3'h6,
		PM_STOP  = 3'h7
	} pmode_t;

	// Reset-cause bit positions
	localparam int CAUSE_POR = 0;
	localparam int CAUSE_EXT = 1;
	localparam int CAUSE_BROWN = 2;
	localparam int CAUSE_WDT = 3;
	localparam int CAUSE_SW  = 4;
	localparam int CAUSE_W   = 5;
	localparam logic [4:0] CAUSE_RESET = 5'h01;

	// One divider's setting: divide by value plus one, optional extra half step
	typedef struct packed {
		logic             frac_en;
		logic [DIV_W-1:0] value;
	} div_cfg_t;

	// Watchdog setting
	typedef struct packed {
		logic        enable;
		logic        use_watch;
		logic [15:0] limit;
	} wdt_cfg_t;

endpackage : clock_reset_power_pkg

// [design/sync2.sv]
// Two-stage synchroniser for levels entering the mclk domain
`timescale 1ns/1ns
module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t st_reg;
	sync_state_t st_next;

	// First stage feeds only the second
	always_comb begin
		st_next        = st_reg;
		st_next.meta   = d;
		st_next.stable = st_reg.meta;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.stable;
endmodule : sync2

// [design/frac_divider.sv]
// One peripheral clock divider counting root clock edges
`timescale 1ns/1ns
module frac_divider #(
	parameter bit HAS_FRAC = 1'b0
) (
	input  wire logic                            mclk,
	input  wire logic                            rstn,
	input  wire logic                            root_tick,
	input  wire clock_reset_power_pkg::div_cfg_t cfg,
	output logic                                 div_clk
);
	typedef struct packed {
		logic [16:0] cnt;
		logic        half;
		logic        clk;
	} div_state_t;

	div_state_t  st_reg;
	div_state_t  st_next;
	logic [16:0] period;

	// Period alternates N and N+1 for an average of N plus one half
	always_comb begin
		period = {1'b0, cfg.value} + {16'h0000, HAS_FRAC & cfg.frac_en & st_reg.half};
		if (period == 17'h00000) begin
			period = 17'h00001;
		end
		st_next = st_reg;
		if (root_tick) begin
			if (st_reg.cnt >= period) begin
				st_next.cnt  = 17'h00000;
				st_next.half = ~st_reg.half;
			end else begin
				st_next.cnt = st_reg.cnt + 17'h00001;
			end
		end
		st_next.clk = (st_next.cnt <= (period >> 1));
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign div_clk = st_reg.clk;
endmodule : frac_divider

// [design/clock_reset_power_control.sv]
// Clock source switch, divider bank, watchdog, reset gathering and power mode control
`timescale 1ns/1ns
module clock_reset_power_control #(
	parameter int FLASH_ROW_LIMIT = clock_reset_power_pkg::FLASH_ROW_CYCLES
) (
	input  wire logic                                 mclk,
	input  wire logic                                 rstn,
	input  wire logic [4:0]                           osc_in,
	input  wire clock_reset_power_pkg::clk_src_t      clk_sel,
	input  wire logic [5:0]                           main_osc_req,
	input  wire logic                                 flash_busy,
	input  wire clock_reset_power_pkg::div_cfg_t [11:0] div_cfg,
	input  wire logic [15:0][3:0]                     pclk_sel,
	input  wire logic [3:0]                           analog_sel,
	input  wire clock_reset_power_pkg::wdt_cfg_t      wdt_cfg,
	input  wire logic                                 wdt_service,
	input  wire logic                                 external_reset_pin_n,
	input  wire logic                                 sw_reset_req,
	input  wire logic                                 brownout_detector,
	input  wire logic                                 low_voltage_detector,
	input  wire logic [4:0]                           volt_threshold,
	input  wire logic                                 volt_irq_clear,
	input  wire logic                                 cause_clear,
	input  wire logic                                 supply_ready,
	input  wire clock_reset_power_pkg::pmode_t        mode_req,
	input  wire logic                                 mode_req_valid,
	input  wire logic [31:0]                          irq,
	input  wire logic [31:0]                          irq_en,
	input  wire logic                                 hib_wake,
	output logic                                      high_frequency_root_clock,
	output logic [5:0]                                main_osc_mhz,
	output logic                                      flash_overtime,
	output logic [15:0]                               periph_clk,
	output logic                                      analog_clk,
	output logic                                      radio_active_clk,
	output logic                                      radio_sleep_clk,
	output logic                                      sys_reset_n,
	output logic [4:0]                                reset_cause,
	output logic [4:0]                                volt_threshold_code,
	output logic                                      volt_irq,
	output clock_reset_power_pkg::pmode_t             power_mode,
	output logic                                      cpu_power_on
);
	typedef struct packed {
		logic [2:0]  cur_src;
		logic        switching;
		logic        root_clk;
		logic        root_prev;
		logic [5:0]  main_mhz;
		logic [31:0] flash_cnt;
		logic        flash_over;
		logic [11:0] div_d;
		logic [15:0] pclk;
		logic        aclk;
		logic        radio_act;
		logic        radio_sleep;
		logic        wdt_prev;
		logic [15:0] wdt_cnt;
		logic        int_rst;
		logic [3:0]  hold;
		logic [4:0]  cause;
		logic        ext_prev;
		logic        volt_prev;
		logic [4:0]  volt_code;
		logic        volt_irq;
		clock_reset_power_pkg::pmode_t mode;
		logic        cpu_on;
	} ctl_state_t;

	ctl_state_t  st_reg;
	ctl_state_t  st_next;
	logic [4:0]  osc_s;
	logic [3:0]  misc_s;
	logic        ext_n_s;
	logic        brown_s;
	logic        volt_s;
	logic        supply_s;
	logic [11:0] div_clk;
	logic        root_tick;
	logic        wdt_src;
	logic        wdt_expire;
	logic        wake;
	logic        chain_rstn;
	logic [2:0]  want_src;

	// Oscillator levels and pin inputs enter through synchronisers
	sync2 #(.WIDTH(5)) u_osc_sync (
		.mclk (mclk),
		.rstn (rstn),
		.d    (osc_in),
		.q    (osc_s)
	);

	sync2 #(.WIDTH(4)) u_pin_sync (
		.mclk (mclk),
		.rstn (rstn),
		.d    ({external_reset_pin_n, brownout_detector, low_voltage_detector, supply_ready}),
		.q    (misc_s)
	);

	assign ext_n_s  = misc_s[3];
	assign brown_s  = misc_s[2];
	assign volt_s   = misc_s[1];
	assign supply_s = misc_s[0];

	// Reset chain: asserts at once on any source, releases through two flops
	assign chain_rstn = rstn & external_reset_pin_n & ~st_reg.int_rst;

	sync2 #(.WIDTH(1)) u_rst_sync (
		.mclk (mclk),
		.rstn (chain_rstn),
		.d    (1'b1),
		.q    (sys_reset_n)
	);

	// Divider bank, the last ones with the half step
	assign root_tick = st_reg.root_clk & ~st_reg.root_prev;

	for (genvar i = 0; i < clock_reset_power_pkg::NUM_DIV; i++) begin : g_div
		frac_divider #(
			.HAS_FRAC (i >= clock_reset_power_pkg::NUM_DIV - clock_reset_power_pkg::NUM_FRAC)
		) u_div (
			.mclk      (mclk),
			.rstn      (rstn),
			.root_tick (root_tick),
			.cfg       (div_cfg[i]),
			.div_clk   (div_clk[i])
		);
	end

	// Watchdog source and expiry
	assign wdt_src    = wdt_cfg.use_watch ? osc_s[clock_reset_power_pkg::SRC_WATCH]
	                                      : osc_s[clock_reset_power_pkg::SRC_SLOW];
	assign wdt_expire = wdt_cfg.enable & (st_reg.wdt_cnt >= wdt_cfg.limit);
	assign wake       = |(irq & irq_en);

	// Only Deep-Sleep forces peripheral clocks onto the low-speed oscillator; hibernate and stop keep clk_sel
	always_comb begin
		want_src = clk_sel;
		if (st_reg.mode == clock_reset_power_pkg::PM_DEEP) begin
			want_src = clock_reset_power_pkg::SRC_SLOW;
		end else if (clk_sel > clock_reset_power_pkg::SRC_EXT) begin
			want_src = clock_reset_power_pkg::SRC_MAIN;
		end
	end

	// Next-state logic of the whole controller
	always_comb begin
		st_next = st_reg;

		// Glitch-free switch: hold low until both old and new sources are low
		st_next.root_prev = st_reg.root_clk;
		if (want_src != st_reg.cur_src && !st_reg.root_clk) begin
			st_next.switching = 1'b1;
		end
		if (st_reg.switching) begin
			st_next.root_clk = 1'b0;
			if (!osc_s[want_src]) begin
				st_next.cur_src   = want_src;
				st_next.switching = 1'b0;
			end
		end else if (want_src == st_reg.cur_src || st_reg.root_clk) begin
			st_next.root_clk = osc_s[st_reg.cur_src];
		end

		// Main oscillator setting, forced during flash operations
		if (flash_busy) begin
			st_next.main_mhz = clock_reset_power_pkg::MAIN_FLASH_MHZ;
		end else if (main_osc_req < clock_reset_power_pkg::MAIN_MIN_MHZ) begin
			st_next.main_mhz = clock_reset_power_pkg::MAIN_MIN_MHZ;
		end else if (main_osc_req > clock_reset_power_pkg::MAIN_MAX_MHZ) begin
			st_next.main_mhz = clock_reset_power_pkg::MAIN_MAX_MHZ;
		end else begin
			st_next.main_mhz = main_osc_req;
		end

		// Flash row time watch
		if (!flash_busy) begin
			st_next.flash_cnt  = 32'h00000000;
			st_next.flash_over = 1'b0;
		end else if (st_reg.flash_cnt >= 32'(FLASH_ROW_LIMIT)) begin
			st_next.flash_over = 1'b1;
		end else begin
			st_next.flash_cnt = st_reg.flash_cnt + 32'h00000001;
		end

		// Analog taken one stage ahead of the digital outputs
		st_next.div_d = div_clk;
		st_next.aclk  = div_clk[analog_sel[3:0]] & (analog_sel < 4'hc);
		for (int k = 0; k < clock_reset_power_pkg::NUM_PCLK; k++) begin
			st_next.pclk[k] = st_reg.div_d[pclk_sel[k]] & (pclk_sel[k] < 4'hc);
		end

		// Radio clocks
		st_next.radio_act   = osc_s[clock_reset_power_pkg::SRC_FAST];
		st_next.radio_sleep = osc_s[clock_reset_power_pkg::SRC_WATCH];

		// Watchdog counts low-speed edges in every power mode
		st_next.wdt_prev = wdt_src;
		if (st_reg.int_rst || wdt_service || !wdt_cfg.enable) begin
			st_next.wdt_cnt = 16'h0000;
		end else if (wdt_src && !st_reg.wdt_prev) begin
			st_next.wdt_cnt = st_reg.wdt_cnt + 16'h0001;
		end

		// Internal reset request held for a fixed count
		st_next.ext_prev = ext_n_s;
		if (st_reg.hold != 4'h0) begin
			st_next.hold = st_reg.hold - 4'h1;
		end else begin
			st_next.int_rst = 1'b0;
		end
		if (wdt_expire || sw_reset_req || brown_s) begin
			st_next.int_rst = 1'b1;
			st_next.hold    = clock_reset_power_pkg::RESET_HOLD_CYCLES;
		end

		// Cause record: software clear first, new causes win
		if (cause_clear) begin
			st_next.cause = 5'h00;
		end
		if (wdt_expire) begin
			st_next.cause[clock_reset_power_pkg::CAUSE_WDT] = 1'b1;
		end
		if (sw_reset_req) begin
			st_next.cause[clock_reset_power_pkg::CAUSE_SW] = 1'b1;
		end
		if (brown_s) begin
			st_next.cause[clock_reset_power_pkg::CAUSE_BROWN] = 1'b1;
		end
		if (!ext_n_s && st_reg.ext_prev) begin
			st_next.cause[clock_reset_power_pkg::CAUSE_EXT] = 1'b1;
		end

		// Low-voltage threshold and sticky interrupt
		st_next.volt_code = (volt_threshold > clock_reset_power_pkg::VOLT_CODE_MAX)
		                    ? clock_reset_power_pkg::VOLT_CODE_MAX : volt_threshold;
		st_next.volt_prev = volt_s;
		if (volt_irq_clear) begin
			st_next.volt_irq = 1'b0;
		end
		if (volt_s && !st_reg.volt_prev) begin
			st_next.volt_irq = 1'b1;
		end

		// Power mode sequencing
		case (st_reg.mode)
			clock_reset_power_pkg::PM_WAIT: begin
				if (supply_s) begin
					st_next.mode = clock_reset_power_pkg::PM_ACT;
				end
			end
			clock_reset_power_pkg::PM_ACT: begin
				if (mode_req_valid && mode_req != clock_reset_power_pkg::PM_WAIT) begin
					st_next.mode = mode_req;
				end
			end
			clock_reset_power_pkg::PM_SLEEP: begin
				if (wake) begin
					st_next.mode = clock_reset_power_pkg::PM_ACT;
				end
			end
			clock_reset_power_pkg::PM_DEEP: begin
				if (wake) begin
					st_next.mode = clock_reset_power_pkg::PM_WAIT;
				end
			end
			clock_reset_power_pkg::PM_HIB: begin
				if (hib_wake) begin
					st_next.mode = clock_reset_power_pkg::PM_WAIT;
				end
			end
			clock_reset_power_pkg::PM_STOP: begin
				st_next.mode = clock_reset_power_pkg::PM_STOP;
			end
			default: begin
				st_next.mode = clock_reset_power_pkg::PM_WAIT;
			end
		endcase
		if (st_reg.int_rst || !ext_n_s) begin
			st_next.mode = clock_reset_power_pkg::PM_WAIT;
		end
		st_next.cpu_on = (st_next.mode == clock_reset_power_pkg::PM_ACT)
		               || (st_next.mode == clock_reset_power_pkg::PM_SLEEP);
	end

	// Only power-on reset returns this state to its initial values
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_reg          <= '0;
			st_reg.main_mhz <= clock_reset_power_pkg::MAIN_RESET_MHZ;
			st_reg.cause    <= clock_reset_power_pkg::CAUSE_RESET;
			st_reg.ext_prev <= 1'b0; // Matches the synchroniser's reset level, no false edge
			st_reg.mode     <= clock_reset_power_pkg::PM_WAIT;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign high_frequency_root_clock = st_reg.root_clk;
	assign main_osc_mhz              = st_reg.main_mhz;
	assign flash_overtime            = st_reg.flash_over;
	assign periph_clk                = st_reg.pclk;
	assign analog_clk                = st_reg.aclk;
	assign radio_active_clk          = st_reg.radio_act;
	assign radio_sleep_clk           = st_reg.radio_sleep;
	assign reset_cause               = st_reg.cause;
	assign volt_threshold_code       = st_reg.volt_code;
	assign volt_irq                  = st_reg.volt_irq;
	assign power_mode                = st_reg.mode;
	assign cpu_power_on              = st_reg.cpu_on;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence switch_pending_s;
		st_reg.switching;
	endsequence

	no_runt_a: assert property (switch_pending_s |-> !st_reg.root_clk)
		else $error("root clock high while switching");

	main_flash_a: assert property (flash_busy |=> main_osc_mhz == clock_reset_power_pkg::MAIN_FLASH_MHZ)
		else $error("oscillator not forced to 48 MHz during flash");

	main_range_a: assert property (main_osc_mhz >= clock_reset_power_pkg::MAIN_MIN_MHZ
		&& main_osc_mhz <= clock_reset_power_pkg::MAIN_MAX_MHZ)
		else $error("oscillator setting out of range");

	sequence wdt_fire_s;
		wdt_expire ##1 st_reg.int_rst;
	endsequence

	wdt_reset_a: assert property (wdt_fire_s |-> ##[0:2] !sys_reset_n)
		else $error("watchdog expiry did not reset");

	wdt_cause_a: assert property (wdt_expire |=> reset_cause[3])
		else $error("watchdog cause not recorded");

	cause_sticky_a: assert property (|($past(reset_cause) & ~reset_cause) |-> $past(cause_clear))
		else $error("cause bit lost without software clear");

	analog_lead_a: assert property (
		($stable(pclk_sel[0]) && pclk_sel[0] == analog_sel && $rose(analog_clk)) ##1 $stable(pclk_sel[0])
		|-> $rose(periph_clk[0]))
		else $error("analog clock does not lead digital clock");

	supply_wait_a: assert property (
		(power_mode == clock_reset_power_pkg::PM_WAIT && !supply_s) |=> power_mode == clock_reset_power_pkg::PM_WAIT)
		else $error("mode entered before supply ready");

	deep_wake_a: assert property (
		(power_mode == clock_reset_power_pkg::PM_DEEP && wake && !st_reg.int_rst) |=> cpu_power_on == 1'b0
		##1 1'b1)
		else $error("deep sleep wake misbehaved");

	sw_reset_a: assert property ($rose(sw_reset_req) |-> ##[1:3] !sys_reset_n)
		else $error("software reset not asserted");
endmodule : clock_reset_power_control

// [bench/periph_model.sv]
// Peripheral-side model that measures a divided clock and its analog lead
`timescale 1ns/1ns
module periph_model (
	input  wire logic        mclk,
	input  wire logic        sys_reset_n,
	input  wire logic        pclk,
	input  wire logic        aclk,
	output logic      [15:0] period,
	output logic             lead_ok
);
	logic [15:0] cnt_reg;
	logic        p_reg;
	logic        a_reg;
	logic        a2_reg;

	// Held in reset with the rest of the peripherals; spacing of rising pclk edges
	always_ff @(posedge mclk or negedge sys_reset_n) begin
		if (!sys_reset_n) begin
			cnt_reg <= 16'h0000;
			p_reg   <= 1'b0;
			a_reg   <= 1'b0;
			a2_reg  <= 1'b0;
			period  <= 16'h0000;
			lead_ok <= 1'b0;
		end else begin
			p_reg  <= pclk;
			a_reg  <= aclk;
			a2_reg <= a_reg;
			if (pclk && !p_reg) begin
				period  <= cnt_reg + 16'h0001;
				cnt_reg <= 16'h0000;
				lead_ok <= a_reg && !a2_reg;
			end else begin
				cnt_reg <= cnt_reg + 16'h0001;
			end
		end
	end
endmodule : periph_model

// [bench/clock_reset_power_control_tb.sv]
// Testbench for the clock, reset and power controller
`timescale 1ns/1ns
module clock_reset_power_control_tb;
	logic mclk = 1'b0, rstn = 1'b0;
	logic [4:0] osc_in = 5'h00;
	clock_reset_power_pkg::clk_src_t clk_sel = clock_reset_power_pkg::SRC_MAIN;
	logic [5:0] main_osc_req = 6'h18;
	logic flash_busy = 1'b0, wdt_service = 1'b0, external_reset_pin_n = 1'b1, sw_reset_req = 1'b0;
	clock_reset_power_pkg::div_cfg_t [11:0] div_cfg = '0;
	logic [15:0][3:0] pclk_sel = '0;
	logic [3:0] analog_sel = 4'h0;
	clock_reset_power_pkg::wdt_cfg_t wdt_cfg = '0;
	logic brownout_detector = 1'b0, low_voltage_detector = 1'b0, volt_irq_clear = 1'b0;
	logic [4:0] volt_threshold = 5'h00;
	logic cause_clear = 1'b0, supply_ready = 1'b0, mode_req_valid = 1'b0, hib_wake = 1'b0;
	clock_reset_power_pkg::pmode_t mode_req = clock_reset_power_pkg::PM_ACT;
	logic [31:0] irq = 32'h0, irq_en = 32'h0;
	logic high_frequency_root_clock, flash_overtime, analog_clk, radio_active_clk, radio_sleep_clk;
	logic sys_reset_n, volt_irq, cpu_power_on, lead_ok;
	logic [5:0] main_osc_mhz;
	logic [15:0] periph_clk, period;
	logic [4:0] reset_cause, volt_threshold_code;
	logic [2:0] watch_vec;
	int n;
	clock_reset_power_pkg::pmode_t power_mode;
	int num_errors = 0, checks = 0;

	clock_reset_power_control #(.FLASH_ROW_LIMIT(50)) dut (
		.mclk, .rstn, .osc_in, .clk_sel, .main_osc_req, .flash_busy, .div_cfg, .pclk_sel, .analog_sel,
		.wdt_cfg, .wdt_service, .external_reset_pin_n, .sw_reset_req, .brownout_detector,
		.low_voltage_detector, .volt_threshold, .volt_irq_clear, .cause_clear, .supply_ready, .mode_req,
		.mode_req_valid, .irq, .irq_en, .hib_wake, .high_frequency_root_clock, .main_osc_mhz, .flash_overtime,
		.periph_clk, .analog_clk, .radio_active_clk, .radio_sleep_clk, .sys_reset_n, .reset_cause,
		.volt_threshold_code, .volt_irq, .power_mode, .cpu_power_on
	);
	// Clocks whose edges are counted: root, radio active, radio sleep
	assign watch_vec = {radio_sleep_clk, radio_active_clk, high_frequency_root_clock};
	periph_model consumer (.mclk(mclk), .sys_reset_n(sys_reset_n), .pclk(periph_clk[0]),
		.aclk(analog_clk), .period(period), .lead_ok(lead_ok));

	// 100 MHz system clock and free-running oscillator levels, toggled on falling edges
	initial forever #5 mclk = ~mclk;
	initial forever #40 osc_in[0] = ~osc_in[0];
	initial forever #100 osc_in[1] = ~osc_in[1];
	initial forever #20 osc_in[2] = ~osc_in[2];
	initial forever #150 osc_in[3] = ~osc_in[3];
	initial forever #60 osc_in[4] = ~osc_in[4];

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Rising edges of one watched clock over n cycles
	task automatic count_rise(input int sel, input int cyc_n, output int cnt);
		logic prev;
		cnt = 0;
		prev = watch_vec[sel];
		repeat (cyc_n) begin
			cyc(1);
			if (watch_vec[sel] === 1'b1 && prev === 1'b0)
				cnt++;
			prev = watch_vec[sel];
		end
	endtask : count_rise

	// Bounded wait for a power mode, then compare
	task automatic wait_mode(input clock_reset_power_pkg::pmode_t m);
		int i;
		for (i = 0; i < 60 && power_mode !== m; i++) cyc(1);
		check({13'h0, power_mode}, {13'h0, m});
	endtask : wait_mode

	// Bounded wait for an internal reset pulse to come and go
	task automatic wait_reset;
		int i;
		for (i = 0; i < 600 && sys_reset_n !== 1'b0; i++) cyc(1);
		check({15'h0, sys_reset_n}, 16'h0000);
		for (i = 0; i < 60 && sys_reset_n !== 1'b1; i++) cyc(1);
		cyc(2);
	endtask : wait_reset

	task automatic pulse(ref logic s, input int n);
		s = 1'b1;
		cyc(n);
		s = 1'b0;
		cyc(1);
	endtask : pulse

	task automatic complete_run;
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	initial begin
		#200000;
		num_errors++;
		complete_run();
	end

	initial begin
		div_cfg[0] = '{frac_en: 1'b0, value: 16'h0003};
		cyc(20);
		check({10'h0, main_osc_mhz}, 16'h0018);
		check({11'h0, reset_cause}, 16'h0001);
		check({13'h0, power_mode}, 16'h0000);
		rstn = 1'b1;
		cyc(10);
		check({13'h0, power_mode}, 16'h0000);
		supply_ready = 1'b1;
		wait_mode(clock_reset_power_pkg::PM_ACT);
		check({11'h0, reset_cause}, 16'h0001);
		$display("reset and supply test done");
		main_osc_req = 6'h0a;
		cyc(3);
		check({10'h0, main_osc_mhz}, 16'h000a);
		flash_busy = 1'b1;
		cyc(2);
		check({10'h0, main_osc_mhz}, 16'h0030);
		cyc(60);
		check({15'h0, flash_overtime}, 16'h0001);
		flash_busy = 1'b0;
		cyc(3);
		check({10'h0, main_osc_mhz}, 16'h000a);
		check({15'h0, flash_overtime}, 16'h0000);
		$display("oscillator test done");
		cyc(300);
		check(period, 16'h0020);
		check({15'h0, lead_ok}, 16'h0001);
		count_rise(0, 40, n);
		check(16'(n), 16'h0005);
		count_rise(1, 40, n);
		check(16'(n), 16'h000a);
		count_rise(2, 60, n);
		check(16'(n), 16'h0002);
		clk_sel = clock_reset_power_pkg::SRC_FAST;
		cyc(20);
		count_rise(0, 40, n);
		check(16'(n), 16'h000a);
		clk_sel = clock_reset_power_pkg::SRC_EXT;
		cyc(20);
		count_rise(0, 48, n);
		check(16'(n), 16'h0004);
		clk_sel = clock_reset_power_pkg::SRC_MAIN;
		cyc(20);
		$display("divider and source test done");
		mode_req = clock_reset_power_pkg::PM_SLEEP;
		pulse(mode_req_valid, 1);
		wait_mode(clock_reset_power_pkg::PM_SLEEP);
		check({15'h0, cpu_power_on}, 16'h0001);
		irq_en = 32'h0000_0008;
		irq = 32'h0000_0008;
		wait_mode(clock_reset_power_pkg::PM_ACT);
		irq = 32'h0;
		mode_req = clock_reset_power_pkg::PM_DEEP;
		pulse(mode_req_valid, 1);
		wait_mode(clock_reset_power_pkg::PM_DEEP);
		cyc(3);
		check({15'h0, cpu_power_on}, 16'h0000);
		cyc(20);
		count_rise(0, 40, n);
		check(16'(n), 16'h0002);
		irq = 32'h0000_0008;
		wait_mode(clock_reset_power_pkg::PM_ACT);
		irq = 32'h0;
		mode_req = clock_reset_power_pkg::PM_HIB;
		pulse(mode_req_valid, 1);
		wait_mode(clock_reset_power_pkg::PM_HIB);
		pulse(hib_wake, 1);
		wait_mode(clock_reset_power_pkg::PM_ACT);
		$display("power mode test done");
		wdt_cfg = '{enable: 1'b1, use_watch: 1'b0, limit: 16'h0004};
		repeat (5) begin
			pulse(wdt_service, 1);
			cyc(19);
		end
		check({15'h0, sys_reset_n}, 16'h0001);
		wait_reset();
		wdt_cfg = '0;
		check({15'h0, reset_cause[3]}, 16'h0001);
		cyc(20);
		check({15'h0, reset_cause[3]}, 16'h0001);
		pulse(cause_clear, 1);
		check({11'h0, reset_cause}, 16'h0000);
		pulse(sw_reset_req, 1);
		wait_reset();
		check({11'h0, reset_cause}, 16'h0010);
		pulse(cause_clear, 1);
		external_reset_pin_n = 1'b0;
		cyc(1);
		check({15'h0, sys_reset_n}, 16'h0000);
		cyc(4);
		external_reset_pin_n = 1'b1;
		cyc(20);
		check({11'h0, reset_cause}, 16'h0002);
		pulse(cause_clear, 1);
		pulse(brownout_detector, 4);
		wait_reset();
		check({11'h0, reset_cause}, 16'h0004);
		wait_mode(clock_reset_power_pkg::PM_ACT);
		$display("reset cause test done");
		volt_threshold = 5'h1f;
		pulse(low_voltage_detector, 6);
		check({11'h0, volt_threshold_code}, 16'h001b);
		check({15'h0, volt_irq}, 16'h0001);
		pulse(volt_irq_clear, 1);
		cyc(1);
		check({15'h0, volt_irq}, 16'h0000);
		$display("low voltage test done");
		complete_run();
	end
endmodule : clock_reset_power_control_tb
